//--- core/wort_map.vh
// Register map, field positions, reset values and timing counts of the wake timer.
`ifndef WORT_MAP_VH
`define WORT_MAP_VH
`define WORT_ADDR_TIMEOUT_HIGH 6'h1e
`define WORT_ADDR_TIMEOUT_LOW 6'h1f
`define WORT_ADDR_CONTROL 6'h20
`define WORT_RST_TIMEOUT_HIGH 8'h87
`define WORT_RST_TIMEOUT_LOW 8'h6b
`define WORT_RST_CONTROL 8'hf8
`define WORT_BIT_PWRDN 7
`define WORT_FLD_SEC_HI 6
`define WORT_FLD_SEC_LO 4
`define WORT_BIT_CAL_EN 3
`define WORT_FLD_RES_HI 1
`define WORT_FLD_RES_LO 0
`define WORT_CTRL_RW_MASK 8'hfb
`define WORT_RC_DIVIDE 750
`define WORT_RC_LIMIT 10'h2ed
`define WORT_PRE_RES0 15'h0000
`define WORT_PRE_RES1 15'h001f
`define WORT_PRE_RES2 15'h03ff
`define WORT_PRE_RES3 15'h7fff
`define WORT_CAL_RC_PERIODS 6'h08
`endif

//--- core/wort_div.v
// Free-running modulo counter that pulses once every limit plus one enabled cycles.
`timescale 1ns/100ps
module wort_div #(
    parameter W = 10
) (
    input wire sys_clk_i,
    input wire rst_b_i,
    input wire clr_i,
    input wire en_i,
    input wire [W-1:0] limit_i,
    output wire tick_o
);
    reg [W-1:0] cnt_q;
    reg [W-1:0] cnt_d;

    // The tick marks the enabled cycle in which the count sits at or above its limit.
    assign tick_o = en_i && (cnt_q >= limit_i);

    // Next count clears on clr_i, wraps to zero on the tick, and otherwise holds while not enabled.
    always @* begin
        cnt_d = cnt_q;
        if (clr_i) begin
            cnt_d = {W{1'b0}};
        end else if (tick_o) begin
            cnt_d = {W{1'b0}};
        end else if (en_i) begin
            cnt_d = cnt_q + {{(W-1){1'b0}}, 1'b1};
        end
    end

    // Count register with synchronous reset.
    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            cnt_q <= {W{1'b0}};
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule // wort_div

//--- core/wort_timer.v
// Wake timer: timeout and control registers, RC tick, primary and secondary events.
//
// Contract
// R01: Timeout low byte resets to 0x6b.
// R02: Power-down resets 1; clearing starts calibration.
// R03: RC clock is crystal clock divided 750.
// R04: Secondary delay code picks 4 to 48 periods.
// R05: Calibration enable bit gates RC calibration.
// R06: Resolution code scales one timeout LSB.
// R07: Software keeps resolution 0/1 for wake-listen.
// R08: Timeout equals value times scaled periods; high 0x87.
// R09: Count, fire primary, restart, then secondary.
`timescale 1ns/100ps
`include "wort_map.vh"
module wort_timer (
    input wire sys_clk_i,
    input wire rst_b_i,
    input wire [5:0] reg_addr_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_wdata_i,
    output wire [7:0] reg_rdata_o,
    output wire rc_tick_o,
    output wire cal_busy_o,
    output wire primary_event_o,
    output wire secondary_event_o
);
    // Programmable registers and the counting state of the timer.
    reg [7:0] timeout_high_q;
    reg [7:0] timeout_low_q;
    reg [7:0] control_q;
    reg [7:0] rdata_q;
    reg [15:0] lsb_cnt_q;
    reg [5:0] sec_cnt_q;
    reg sec_act_q;
    reg [5:0] cal_cnt_q;
    reg cal_act_q;
    reg prim_ev_q;
    reg sec_ev_q;
    reg [14:0] pre_limit;
    reg [5:0] sec_periods;
    // Decoded control fields and internal strobes.
    wire rc_osc_powerdown;
    wire rc_osc_cal_enable;
    wire [2:0] secondary_wake_delay;
    wire [1:0] wake_timer_resolution;
    wire [15:0] primary_wake_timeout;
    wire rc_tick;
    wire lsb_tick;
    wire running;
    wire ctrl_wr;
    wire cal_start;
    wire prim_hit;

    // Control fields, and the 16-bit timeout built from its two byte registers.
    assign rc_osc_powerdown = control_q[`WORT_BIT_PWRDN];
    assign rc_osc_cal_enable = control_q[`WORT_BIT_CAL_EN];
    assign secondary_wake_delay = control_q[`WORT_FLD_SEC_HI:`WORT_FLD_SEC_LO];
    assign wake_timer_resolution = control_q[`WORT_FLD_RES_HI:`WORT_FLD_RES_LO];
    assign primary_wake_timeout = {timeout_high_q, timeout_low_q};
    // The control write is decoded once and shared by the register and calibration logic.
    assign ctrl_wr = reg_wr_i && (reg_addr_i == `WORT_ADDR_CONTROL);
    // Calibration starts when software clears a set power-down bit with calibration enabled.
    assign cal_start = ctrl_wr && rc_osc_powerdown && !reg_wdata_i[`WORT_BIT_PWRDN] &&
        reg_wdata_i[`WORT_BIT_CAL_EN]; // [R02] [R05]
    // The timer only counts while powered up and not calibrating.
    assign running = !rc_osc_powerdown && !cal_act_q;

    // The RC oscillator ticks once per 750 crystal cycles while powered up.
    wort_div #(
        .W(10)
    ) u_rc_div (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .clr_i(rc_osc_powerdown),
        .en_i(!rc_osc_powerdown),
        .limit_i(`WORT_RC_LIMIT), // [R03]
        .tick_o(rc_tick)
    );

    // Resolution picks how many RC periods make one timeout LSB.
    always @* begin
        case (wake_timer_resolution)
            2'h0: pre_limit = `WORT_PRE_RES0; // [R06]
            2'h1: pre_limit = `WORT_PRE_RES1;
            2'h2: pre_limit = `WORT_PRE_RES2;
            default: pre_limit = `WORT_PRE_RES3;
        endcase
    end

    // The prescaler restarts whenever the timer is halted.
    wort_div #(
        .W(15)
    ) u_pre_div (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .clr_i(!running),
        .en_i(running && rc_tick),
        .limit_i(pre_limit), // [R06] [R08]
        .tick_o(lsb_tick)
    );

    // Secondary delay code decodes to a count of RC periods.
    always @* begin
        case (secondary_wake_delay)
            3'h0: sec_periods = 6'h04; // [R04]
            3'h1: sec_periods = 6'h06;
            3'h2: sec_periods = 6'h08;
            3'h3: sec_periods = 6'h0c;
            3'h4: sec_periods = 6'h10;
            3'h5: sec_periods = 6'h18;
            3'h6: sec_periods = 6'h20;
            default: sec_periods = 6'h30;
        endcase
    end

    // A timeout of zero behaves as one LSB so the timer never stalls.
    assign prim_hit = lsb_tick &&
        (({1'b0, lsb_cnt_q} + 17'h00001) >= {1'b0, primary_wake_timeout}); // [R08] [R09]

    // Register writes; the unused control bit stays zero.
    // Writes to unmapped addresses leave all three registers untouched.
    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            timeout_high_q <= `WORT_RST_TIMEOUT_HIGH; // [R08]
            timeout_low_q <= `WORT_RST_TIMEOUT_LOW; // [R01]
            control_q <= `WORT_RST_CONTROL; // [R02] [R04] [R05] [R06]
        end else if (reg_wr_i) begin
            if (reg_addr_i == `WORT_ADDR_TIMEOUT_HIGH) begin
                timeout_high_q <= reg_wdata_i;
            end
            if (reg_addr_i == `WORT_ADDR_TIMEOUT_LOW) begin
                timeout_low_q <= reg_wdata_i;
            end
            if (ctrl_wr) begin
                control_q <= reg_wdata_i & `WORT_CTRL_RW_MASK;
            end
        end
    end

    // Read data is registered; unmapped addresses read as zero.
    // A read in the same cycle as a write returns the old value.
    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            rdata_q <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `WORT_ADDR_TIMEOUT_HIGH: rdata_q <= timeout_high_q;
                `WORT_ADDR_TIMEOUT_LOW: rdata_q <= timeout_low_q;
                `WORT_ADDR_CONTROL: rdata_q <= control_q;
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    // Calibration runs a fixed number of RC periods and holds the timer meanwhile.
    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            cal_act_q <= 1'b0;
            cal_cnt_q <= 6'h00;
        end else if (cal_start) begin
            cal_act_q <= 1'b1; // [R02]
            cal_cnt_q <= 6'h00;
        end else if (rc_osc_powerdown || !rc_osc_cal_enable) begin
            // Powering down or clearing the enable bit abandons a running calibration.
            cal_act_q <= 1'b0; // [R05]
            cal_cnt_q <= 6'h00;
        end else if (cal_act_q && rc_tick) begin
            if (cal_cnt_q == (`WORT_CAL_RC_PERIODS - 6'h01)) begin
                cal_act_q <= 1'b0;
            end
            cal_cnt_q <= cal_cnt_q + 6'h01;
        end
    end

    // Primary count advances per LSB and restarts on the timeout.
    // Clearing on the hit itself makes one period exactly N LSBs long.
    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            lsb_cnt_q <= 16'h0000;
            prim_ev_q <= 1'b0;
        end else begin
            prim_ev_q <= prim_hit; // [R09]
            if (!running || prim_hit) begin
                lsb_cnt_q <= 16'h0000; // [R09]
            end else if (lsb_tick) begin
                lsb_cnt_q <= lsb_cnt_q + 16'h0001;
            end
        end
    end

    // Secondary delay counts RC periods from the primary event.
    // A primary hit while a secondary is pending reloads the delay from the start,
    // so a delay longer than the primary period never fires.
    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            sec_act_q <= 1'b0;
            sec_cnt_q <= 6'h00;
            sec_ev_q <= 1'b0;
        end else begin
            sec_ev_q <= 1'b0;
            if (!running) begin
                sec_act_q <= 1'b0;
            end else if (prim_hit) begin
                sec_act_q <= 1'b1; // [R04] [R09]
                sec_cnt_q <= sec_periods;
            end else if (sec_act_q && rc_tick) begin
                if (sec_cnt_q == 6'h01) begin
                    sec_act_q <= 1'b0;
                    sec_ev_q <= 1'b1; // [R04]
                end
                sec_cnt_q <= sec_cnt_q - 6'h01;
            end
        end
    end

    // Outputs come straight from registers, except the RC tick strobe.
    assign reg_rdata_o = rdata_q;
    assign rc_tick_o = rc_tick;
    assign cal_busy_o = cal_act_q;
    assign primary_event_o = prim_ev_q;
    assign secondary_event_o = sec_ev_q;
endmodule // wort_timer

//--- sim/wort_timer_sva.sv
// Assertions on the register port, RC tick and event outputs of the wake timer.
`timescale 1ns/100ps
module wort_timer_sva (
    input wire sys_clk_i,
    input wire rst_b_i,
    input wire [5:0] reg_addr_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_wdata_i,
    input wire [7:0] reg_rdata_o,
    input wire rc_tick_o,
    input wire cal_busy_o,
    input wire primary_event_o,
    input wire secondary_event_o
);
    logic [9:0] gap_q;
    logic gap_ok_q;
    logic pd_q;
    wire ctl_wr = reg_wr_i && reg_addr_i == 6'h20;
    // Mirrors the power-down bit and counts cycles since the last tick.
    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            pd_q <= 1'b1;
            gap_q <= 10'h000;
            gap_ok_q <= 1'b0;
        end else begin
            pd_q <= ctl_wr ? reg_wdata_i[7] : pd_q;
            gap_q <= rc_tick_o ? 10'h000 : gap_q + 10'h001;
            gap_ok_q <= (ctl_wr || cal_busy_o) ? 1'b0 : (rc_tick_o || gap_ok_q);
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    low_rw_a: assert property (reg_wr_i && reg_addr_i == 6'h1f ##1 reg_rd_i && reg_addr_i == 6'h1f
        |=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("low byte readback wrong");
    high_rw_a: assert property (reg_wr_i && reg_addr_i == 6'h1e ##1 reg_rd_i && reg_addr_i == 6'h1e
        |=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("high byte readback wrong");
    ctl_rw_a: assert property (ctl_wr ##1 reg_rd_i && reg_addr_i == 6'h20
        |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'hfb)) else $error("control readback wrong");
    pd_quiet_a: assert property (pd_q |-> !rc_tick_o) else $error("tick while powered down");
    tick_gap_a: assert property (rc_tick_o && gap_ok_q |-> gap_q == 10'd749) else $error("tick gap");
    cal_start_a: assert property (ctl_wr && pd_q && !reg_wdata_i[7] && reg_wdata_i[3]
        |=> cal_busy_o) else $error("calibration not started");
    cal_hold_a: assert property (cal_busy_o |-> !primary_event_o && !secondary_event_o)
        else $error("event during calibration");
    prim_tick_a: assert property (primary_event_o |-> $past(rc_tick_o) ##1 !primary_event_o)
        else $error("primary not one cycle after tick");
    sec_tick_a: assert property (secondary_event_o |-> $past(rc_tick_o) ##1 !secondary_event_o)
        else $error("secondary not one cycle after tick");
    cover property (primary_event_o);
    cover property (secondary_event_o);
    cover property ($rose(cal_busy_o));
endmodule // wort_timer_sva

bind wort_timer wort_timer_sva sva_i (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .rc_tick_o(rc_tick_o),
    .cal_busy_o(cal_busy_o),
    .primary_event_o(primary_event_o),
    .secondary_event_o(secondary_event_o)
);

//--- sim/testbench.sv
// Self-checking bench for the wake timer registers, calibration and events.
`timescale 1ns/100ps
module testbench;
    reg sys_clk_i = 1'b0;
    reg rst_b_i = 1'b0;
    reg [5:0] addr = 6'h00;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg [7:0] wdata = 8'h00;
    wire [7:0] rdata;
    wire tick, busy, pev, sev;
    integer n_mismatch = 0;
    integer check_count = 0;
    integer i;
    integer n;
    reg [22:0] rows [0:7];
    wort_timer dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .rc_tick_o(tick), .cal_busy_o(busy), .primary_event_o(pev), .secondary_event_o(sev));
    // Clock of 5 ns.
    always #2.5 sys_clk_i = ~sys_clk_i;
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", check_count, n_mismatch);
            if (n_mismatch == 0 && check_count > 0) begin
                $display("bench passed");
            end else begin
                $display("bench failed");
            end
            $finish;
        end
    endtask
    task check(input [15:0] seen, input [15:0] exp, input [8*8-1:0] what);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("[FAIL] %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    // Advances one cycle and lets that edge's updates land.
    task step;
        begin
            @(posedge sys_clk_i);
            #1;
        end
    endtask
    // Each strobe is raised one edge after the last one fell.
    task wr_reg(input [5:0] a, input [7:0] d);
        begin
            step;
            addr = a;
            wdata = d;
            wr = 1'b1;
            step;
            wr = 1'b0;
        end
    endtask
    task rd_reg(input [5:0] a);
        begin
            step;
            addr = a;
            rd = 1'b1;
            step;
            rd = 1'b0;
        end
    endtask
    // Write followed by a read of the same address in the very next cycle.
    task wr_rd(input [5:0] a, input [7:0] d);
        begin
            step;
            addr = a;
            wdata = d;
            wr = 1'b1;
            step;
            wr = 1'b0;
            rd = 1'b1;
            step;
            rd = 1'b0;
        end
    endtask
    // Counts RC ticks until the chosen event pulses.
    task ticks(input sel);
        begin
            n = 0;
            while ((sel ? sev : pev) !== 1'b1 && n < 2000) begin
                n = n + (tick === 1'b1);
                step;
            end
        end
    endtask
    task run(input [7:0] lo, input [7:0] ctl, input integer ep, input integer es);
        begin
            wr_reg(6'h20, 8'h80);
            wr_reg(6'h1e, 8'h00);
            wr_reg(6'h1f, lo);
            wr_reg(6'h20, ctl);
            ticks(1'b0);
            check(n, ep, "primary");
            // Coarsest resolution pushes the next primary out so it cannot reload the delay.
            wr_reg(6'h20, ctl | 8'h03);
            ticks(1'b1);
            check(n, es, "second");
            $display("run %h %h done", lo, ctl);
        end
    endtask
    // Cuts a hung run short; the tests need about 80000 cycles.
    initial begin
        #(95000 * 5);
        n_mismatch = n_mismatch + 1;
        stop_test;
    end
    initial begin
        rows[0] = {1'b0, 6'h1e, 8'h00, 8'h87};
        rows[1] = {1'b0, 6'h1f, 8'h00, 8'h6b};
        rows[2] = {1'b0, 6'h20, 8'h00, 8'hf8};
        rows[3] = {1'b0, 6'h05, 8'h00, 8'h00};
        rows[4] = {1'b1, 6'h1f, 8'ha5, 8'ha5};
        rows[5] = {1'b1, 6'h1e, 8'h3c, 8'h3c};
        rows[6] = {1'b1, 6'h20, 8'hf7, 8'hf3};
        rows[7] = {1'b1, 6'h05, 8'h55, 8'h00};
        repeat (6) @(posedge sys_clk_i);
        #1 rst_b_i = 1'b1;
        for (i = 0; i < 8; i = i + 1) begin
            if (rows[i][22]) begin
                wr_rd(rows[i][21:16], rows[i][15:8]);
            end else begin
                rd_reg(rows[i][21:16]);
            end
            check(rdata, rows[i][7:0], "reg");
        end
        $display("register rows done");
        wr_reg(6'h20, 8'h08);
        step;
        n = 0;
        while (busy === 1'b1 && n < 20) begin
            n = n + (tick === 1'b1);
            step;
        end
        check(n, 8, "cal");
        while (tick !== 1'b1) step;
        n = 1;
        step;
        while (tick !== 1'b1 && n < 2000) begin
            n = n + 1;
            step;
        end
        check(n, 750, "tickgap");
        $display("calibration and tick done");
        run(8'h02, 8'h00, 2, 4);
        run(8'h02, 8'h70, 2, 48);
        run(8'h01, 8'h21, 32, 8);
        rst_b_i = 1'b0;
        step;
        rst_b_i = 1'b1;
        check(tick, 1'b0, "tickrst");
        rd_reg(6'h1f);
        check(rdata, 8'h6b, "rerst");
        rd_reg(6'h1e);
        check(rdata, 8'h87, "hirst");
        rd_reg(6'h20);
        check(rdata, 8'hf8, "ctlrst");
        $display("reset in run done");
        stop_test;
    end
endmodule // testbench
